/* rtl/tja_bitbuf.sv */
// Bit-wide elastic store of the attenuator.
// Assumes one write and one read per cycle at most; read data is registered.
`timescale 1ns/1ps
`default_nettype none
module tja_bitbuf #(
    parameter int DEPTH = 128,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic          mclk,
    input  wire logic          srst,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic          wbit,
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic               rbit
);
    import tja_pkg::*;
    typedef struct packed {
        logic [DEPTH-1:0] mem;
        logic             rbit;
    } tja_buf_st_t;
    tja_buf_st_t r;
    tja_buf_st_t next_r;
    always_comb begin
        next_r = r;
        if (we) begin
            next_r.mem[waddr] = wbit;
        end
        if (re) begin
            next_r.rbit = r.mem[raddr];
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign rbit = r.rbit;
endmodule : tja_bitbuf
`default_nettype wire

/* rtl/tja_dpll.sv */
// Digital loop that makes the de-jittered read strobe.
// Assumes a fill error centred on zero and one mclk domain.
`timescale 1ns/1ps
`default_nettype none
module tja_dpll (
    input  wire logic      mclk,
    input  wire logic      srst,
    input  wire tja_pkg::tja_loop_t loop,
    output logic           tick
);
    import tja_pkg::*;
    typedef struct packed {
        logic [31:0]        acc;
        logic signed [31:0] integ;
        logic               tick;
    } tja_dpll_st_t;
    tja_dpll_st_t       r;
    tja_dpll_st_t       next_r;
    logic [31:0]        nom;
    logic signed [31:0] err_w;
    int                 sh;
    logic [31:0]        inc;
    logic [32:0]        sum;
    always_comb begin
        nom = loop.e1 ? NCO_INC_E1 : NCO_INC_T1;
        case ({loop.e1, loop.bw})
            2'b00:   sh = SH_CF_5HZ;
            2'b01:   sh = SH_CF_1P26HZ;
            2'b10:   sh = SH_CF_6P77HZ;
            default: sh = SH_CF_0P87HZ;
        endcase
        err_w = 32'(loop.err) <<< ERR_SCALE;
        // Slow wander passes through the integrator; fast jitter is averaged out
        inc = nom + r.integ + 32'(err_w >>> (sh - PROP_BOOST));
        if (loop.fast) begin
            inc = inc + (nom >> LIMIT_SH);
        end
        if (loop.slow) begin
            inc = inc - (nom >> LIMIT_SH);
        end
        sum = {1'b0, r.acc} + {1'b0, inc};
        next_r = r;
        next_r.tick = 1'b0;
        if (!loop.run) begin
            next_r = '0;
        end else begin
            next_r.acc  = sum[31:0];
            next_r.tick = sum[32];
            if (sum[32]) begin
                next_r.integ = r.integ + (err_w >>> sh);
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign tick = r.tick;
endmodule : tja_dpll
`default_nettype wire

/* rtl/tja_pkg.sv */
// Constants and carrier types of the transmit jitter attenuator.
// Assumes a 125 MHz mclk and APB access to byte-lane registers.
package tja_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONFIG   = 8'h21;
    localparam logic [7:0] IDX_TXCFG0   = 8'h22;
    localparam logic [7:0] IDX_IRQ_EN   = 8'h34;
    localparam logic [7:0] IDX_MEASURE  = 8'h38;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h3B;
    localparam logic [7:0] ADDR_CONFIG   = {IDX_CONFIG[5:0], 2'b00};
    localparam logic [7:0] ADDR_TXCFG0   = {IDX_TXCFG0[5:0], 2'b00};
    localparam logic [7:0] ADDR_IRQ_EN   = {IDX_IRQ_EN[5:0], 2'b00};
    localparam logic [7:0] ADDR_MEASURE  = {IDX_MEASURE[5:0], 2'b00};
    localparam logic [7:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT[5:0], 2'b00};
    // Reset values
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [7:0] TXCFG0_RST = 8'h00;
    localparam logic [7:0] IRQ_EN_RST = 8'h00;
    localparam logic [7:0] STAT_RST   = 8'h00;
    localparam int SLIP_BIT = 0;
    // Buffer depths and limit-mode margins in bits
    localparam logic [7:0] DEPTH_32  = 8'h20;
    localparam logic [7:0] DEPTH_64  = 8'h40;
    localparam logic [7:0] DEPTH_128 = 8'h80;
    localparam logic [7:0] MARGIN_32  = 8'h02;
    localparam logic [7:0] MARGIN_64  = 8'h03;
    localparam logic [7:0] MARGIN_128 = 8'h04;
    localparam logic [6:0] MEAS_MAX = 7'h7F;
    // Read-clock oscillator: increment is line rate over mclk rate
    localparam longint MCLK_HZ    = 125_000_000;
    localparam longint T1_RATE_HZ = 1_544_000;
    localparam longint E1_RATE_HZ = 2_048_000;
    localparam logic [31:0] NCO_INC_T1 = 32'((T1_RATE_HZ << 32) / MCLK_HZ);
    localparam logic [31:0] NCO_INC_E1 = 32'((E1_RATE_HZ << 32) / MCLK_HZ);
    // Loop gain shifts, one per corner; a larger shift is a lower corner
    localparam int SH_CF_5HZ    = 10;
    localparam int SH_CF_1P26HZ = 12;
    localparam int SH_CF_6P77HZ = 10;
    localparam int SH_CF_0P87HZ = 13;
    localparam int ERR_SCALE    = 20;
    localparam int PROP_BOOST   = 4;
    localparam int LIMIT_SH     = 6;
    typedef enum logic [1:0] {
        ST_BYPASS = 2'b00,
        ST_FILL   = 2'b01,
        ST_RUN    = 2'b10
    } tja_state_t;
    typedef struct packed {
        logic [1:0] rsvd;
        logic       peak;
        logic       limit;
        logic       bw;
        logic [1:0] depth;
        logic       en;
    } tja_cfg_t;
    typedef struct packed {
        logic [5:0] rsvd;
        logic       e1;
        logic       off;
    } tja_txcfg_t;
    typedef struct packed {
        logic              run;
        logic              e1;
        logic              bw;
        logic              fast;
        logic              slow;
        logic signed [7:0] err;
    } tja_loop_t;
endpackage : tja_pkg

/* rtl/tja_top.sv */
// Transmit jitter attenuator of one channel with its APB registers.
// Assumes tx clock and data arrive from pins, asynchronous to mclk.
//
// Notes on behaviour
// - Power-down bit set puts both line outputs into high impedance.
// - Enable bit inserts the attenuator in the path or bypasses it.
// - Two-bit depth field picks a 32, 64 or 128 bit buffer.
// - Latency is half the depth: reading starts once the buffer is half full.
// - A digital loop makes the read strobe, smoothing only fast jitter.
// - In T1 mode the bandwidth bit picks the 5 Hz or 1.26 Hz corner.
// - In E1 mode it picks 6.77 Hz or 0.87 Hz; lower corners lock slower.
// - Overflow or underflow of the buffer sets the slip status flag.
// - Interrupt output goes low while slip flag and its enable are set.
// - Limit mode speeds or slows reading as the buffer nears full or empty.
// - Limit action starts 2, 3 or 4 bits from the edge, by depth.
// - Measure mode zero loads the live pointer separation continuously.
// - Measure mode one keeps the largest separation seen.
`timescale 1ns/1ps
`default_nettype none
module tja_top (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_clk_in,
    input  wire logic        tx_data_in,
    output logic             tx_line_pos,
    output logic             tx_line_pos_oe,
    output logic             tx_line_neg,
    output logic             tx_line_neg_oe,
    output logic             tx_out_strobe,
    output logic             int_n
);
    import tja_pkg::*;

    typedef struct packed {
        logic [2:0]  clk_s;
        logic [2:0]  dat_s;
        logic        clk_lvl;
        tja_cfg_t    cfg;
        tja_txcfg_t  txc;
        logic [7:0]  irq_en;
        logic [7:0]  stat;
        logic [6:0]  meas;
        logic [7:0]  wp;
        logic [7:0]  rp;
        tja_state_t  st;
        logic [1:0]  dp_last;
        logic        rd_pend;
        logic        out_bit;
        logic        out_stb;
        logic        line_pos;
        logic        line_neg;
        logic        line_oe;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        int_n;
    } tja_top_st_t;

    tja_top_st_t r;
    tja_top_st_t next_r;

    logic [7:0]  depth;
    logic [7:0]  half;
    logic [7:0]  margin;
    logic [7:0]  fill;
    logic [6:0]  cur;
    logic        rise;
    logic        tick;
    logic        slip;
    logic        setup;
    logic        access;
    logic        hit;
    logic [7:0]  rmux;
    logic [7:0]  clr;
    logic        mem_we;
    logic        mem_re;
    logic        mem_bit;
    tja_loop_t   loop;

    // Depth, centre point and limit margin follow the depth field
    always_comb begin
        case (r.cfg.depth)
            2'b00: begin
                depth  = DEPTH_32;
                margin = MARGIN_32;
            end
            2'b01: begin
                depth  = DEPTH_64;
                margin = MARGIN_64;
            end
            default: begin
                depth  = DEPTH_128;
                margin = MARGIN_128;
            end
        endcase
        half = depth >> 1;
        fill = r.wp - r.rp;
        cur  = fill[7] ? MEAS_MAX : fill[6:0];
    end

    // Loop control; pointers share mclk, so the compare needs no further sync
    always_comb begin
        loop      = '0;
        loop.run  = (r.st == ST_RUN);
        loop.e1   = r.txc.e1;
        loop.bw   = r.cfg.bw;
        loop.err  = 8'(fill - half);
        loop.fast = r.cfg.limit && (fill >= depth - margin);
        loop.slow = r.cfg.limit && (fill <= margin);
    end

    // Register decode and read mux
    always_comb begin
        setup  = psel && !penable;
        access = psel && penable && r.pready;
        hit    = 1'b1;
        case (paddr)
            ADDR_CONFIG:   rmux = r.cfg;
            ADDR_TXCFG0:   rmux = r.txc;
            ADDR_IRQ_EN:   rmux = r.irq_en;
            ADDR_MEASURE:  rmux = {1'b0, r.meas};
            ADDR_IRQ_STAT: rmux = r.stat;
            default: begin
                rmux = 8'h00;
                hit  = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_r         = r;
        slip           = 1'b0;
        mem_we         = 1'b0;
        mem_re         = 1'b0;
        clr            = 8'h00;
        // Pin inputs: three flops, a change counts once stages two and three agree
        next_r.clk_s   = {r.clk_s[1:0], tx_clk_in};
        next_r.dat_s   = {r.dat_s[1:0], tx_data_in};
        rise           = (r.clk_s[1] == r.clk_s[2]) && r.clk_s[2] && !r.clk_lvl;
        if (r.clk_s[1] == r.clk_s[2]) begin
            next_r.clk_lvl = r.clk_s[2];
        end
        next_r.out_stb = 1'b0;
        next_r.rd_pend = 1'b0;
        next_r.dp_last = r.cfg.depth;

        case (r.st)
            ST_BYPASS: begin
                next_r.wp = 8'h00;
                next_r.rp = 8'h00;
                if (rise) begin
                    next_r.out_bit = r.dat_s[2];
                    next_r.out_stb = 1'b1;
                end
                if (r.cfg.en) begin
                    next_r.st = ST_FILL;
                end
            end
            ST_FILL, ST_RUN: begin
                if (rise) begin
                    if (fill >= depth) begin
                        // Overflow: drop this bit and half the store to recentre
                        slip      = 1'b1;
                        next_r.rp = r.rp + half;
                    end else begin
                        mem_we    = 1'b1;
                        next_r.wp = r.wp + 8'h01;
                    end
                end
                if (r.st == ST_FILL) begin
                    if (fill >= half) begin
                        next_r.st = ST_RUN;
                    end
                end else if (tick) begin
                    if (fill == 8'h00) begin
                        // Underflow: stop reading until half full again
                        slip      = 1'b1;
                        next_r.st = ST_FILL;
                    end else begin
                        mem_re         = 1'b1;
                        next_r.rp      = next_r.rp + 8'h01;
                        next_r.rd_pend = 1'b1;
                    end
                end
                if (r.cfg.depth != r.dp_last) begin
                    next_r.st = ST_FILL;
                    next_r.wp = 8'h00;
                    next_r.rp = 8'h00;
                end
                if (!r.cfg.en) begin
                    next_r.st = ST_BYPASS;
                end
            end
            default: begin
                next_r.st = ST_BYPASS;
            end
        endcase

        if (r.rd_pend) begin
            next_r.out_bit = mem_bit;
            next_r.out_stb = 1'b1;
        end

        // Jitter measure: live separation or peak hold
        if (r.cfg.peak) begin
            if (cur > r.meas) begin
                next_r.meas = cur;
            end
        end else begin
            next_r.meas = cur;
        end

        // APB: answer prepared in setup, taken in the access cycle
        next_r.pready = setup;
        if (setup) begin
            next_r.prdata  = {24'h000000, rmux};
            next_r.pslverr = !hit;
        end
        if (access && pwrite && !r.pslverr) begin
            case (paddr)
                ADDR_CONFIG: begin
                    next_r.cfg      = tja_cfg_t'(pwdata[7:0]);
                    next_r.cfg.rsvd = '0;
                end
                ADDR_TXCFG0: begin
                    next_r.txc      = tja_txcfg_t'(pwdata[7:0]);
                    next_r.txc.rsvd = '0;
                end
                ADDR_IRQ_EN: begin
                    next_r.irq_en = pwdata[7:0] & 8'h01;
                end
                default: begin
                    next_r.irq_en = r.irq_en;
                end
            endcase
        end
        // Read clears only what was returned, so a new slip is never lost
        if (access && !pwrite && (paddr == ADDR_IRQ_STAT)) begin
            clr = r.prdata[7:0];
        end
        next_r.stat = (r.stat & ~clr) | {7'h00, slip};
        next_r.int_n = !(|(next_r.stat & next_r.irq_en));

        // Line drivers; released while powered down
        next_r.line_oe  = !next_r.txc.off;
        next_r.line_pos = !next_r.txc.off && next_r.out_bit;
        next_r.line_neg = !next_r.txc.off && !next_r.out_bit;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            r        <= '0;
            r.cfg    <= tja_cfg_t'(CONFIG_RST);
            r.txc    <= tja_txcfg_t'(TXCFG0_RST);
            r.irq_en <= IRQ_EN_RST;
            r.stat   <= STAT_RST;
            r.int_n  <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    tja_bitbuf #(
        .DEPTH (128),
        .AW    (7)
    ) u_buf (
        .mclk  (mclk),
        .srst  (srst),
        .we    (mem_we),
        .waddr (r.wp[6:0]),
        .wbit  (r.dat_s[2]),
        .re    (mem_re),
        .raddr (r.rp[6:0]),
        .rbit  (mem_bit)
    );

    tja_dpll u_dpll (
        .mclk (mclk),
        .srst (srst),
        .loop (loop),
        .tick (tick)
    );

    assign prdata         = r.prdata;
    assign pready         = r.pready;
    assign pslverr        = r.pslverr;
    assign tx_line_pos    = r.line_pos;
    assign tx_line_neg    = r.line_neg;
    assign tx_line_pos_oe = r.line_oe;
    assign tx_line_neg_oe = r.line_oe;
    assign tx_out_strobe  = r.out_stb;
    assign int_n          = r.int_n;

    a_hz_power_down: assert property (
        @(posedge mclk) disable iff (srst)
        (access && pwrite && paddr == ADDR_TXCFG0 && pwdata[0])
        |=> !tx_line_pos_oe && !tx_line_neg_oe && !tx_line_pos && !tx_line_neg)
        else $error("line outputs driven while powered down");

    a_bypass_on_off: assert property (
        @(posedge mclk) disable iff (srst)
        !r.cfg.en ##1 !r.cfg.en |-> r.st == ST_BYPASS)
        else $error("attenuator stays in path while disabled");

    a_fill_bound: assert property (
        @(posedge mclk) disable iff (srst)
        r.st != ST_BYPASS && r.cfg.depth == r.dp_last |-> fill <= depth)
        else $error("buffer fill beyond selected depth");

    a_start_at_half: assert property (
        @(posedge mclk) disable iff (srst)
        r.st == ST_FILL ##1 r.st == ST_RUN |-> $past(fill) >= $past(half))
        else $error("reading started before half depth");

    a_slip_sets: assert property (
        @(posedge mclk) disable iff (srst)
        slip |=> r.stat[SLIP_BIT] ##1 (r.stat[SLIP_BIT] || $past(clr[SLIP_BIT])))
        else $error("slip did not set status");

    a_irq_level: assert property (
        @(posedge mclk) disable iff (srst)
        (r.stat[SLIP_BIT] && r.irq_en[SLIP_BIT]) == !int_n)
        else $error("interrupt output disagrees with status and enable");

    a_limit_edge: assert property (
        @(posedge mclk) disable iff (srst)
        (r.cfg.limit && r.cfg.depth == 2'b00 && fill == 8'h1E) |-> loop.fast)
        else $error("limit action missing two bits from full");

    a_measure_live: assert property (
        @(posedge mclk) disable iff (srst)
        !r.cfg.peak |=> r.meas == $past(cur))
        else $error("measure does not track separation");

    a_peak_hold: assert property (
        @(posedge mclk) disable iff (srst)
        r.cfg.peak ##1 r.cfg.peak |-> r.meas >= $past(r.meas) && r.meas >= $past(cur))
        else $error("peak measure fell");

    a_slip_sticky: assert property (
        @(posedge mclk) disable iff (srst)
        r.stat[SLIP_BIT] && !(access && !pwrite && paddr == ADDR_IRQ_STAT)
        |=> r.stat[SLIP_BIT])
        else $error("slip flag lost without a read");

endmodule : tja_top
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench of the attenuator: APB tasks plus framer model.
// Assumes the package register map and a 125 MHz mclk.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import tja_pkg::*;
    logic        mclk, srst, psel, penable, pwrite, run, chk_line, err;
    logic [7:0]  paddr, half;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, tx_clk, tx_data, strobe, int_n;
    logic        line_pos, pos_oe, line_neg, neg_oe;
    logic [15:0] sent, base, out_cnt, k;
    int          mismatches, total_checks, n, hd;

    tja_top i_dut (.mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_clk_in(tx_clk), .tx_data_in(tx_data), .tx_line_pos(line_pos), .tx_line_pos_oe(pos_oe),
        .tx_line_neg(line_neg), .tx_line_neg_oe(neg_oe), .tx_out_strobe(strobe), .int_n(int_n));
    tja_framer i_frm (.mclk(mclk), .run(run), .half(half), .tx_clk(tx_clk), .tx_data(tx_data), .sent(sent));

    function automatic logic tja_pat(input logic [15:0] n);
        return n[0] ^ n[2] ^ (n[1] & n[3]);
    endfunction : tja_pat

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    task automatic tmo(input int cnt, input int lim);
        if (cnt >= lim) begin
            mismatches++;
            $display("[ERR] %0t wait ran out", $time);
            close_out();
        end
    endtask : tmo

    // Request held until pready is seen high; no latency assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int w;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        w = 0;
        do begin
            @(posedge mclk);
            w++;
        end while (pready !== 1'b1 && w < 20);
        if (pready !== 1'b1) tmo(20, 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_bits(input logic [15:0] target);
        for (n = 0; n < 20000 && sent != target; n++) @(posedge mclk);
        tmo(n, 20000);
    endtask : wait_bits

    task automatic wait_out();
        for (n = 0; n < 30000 && out_cnt == base; n++) @(posedge mclk);
        tmo(n, 30000);
    endtask : wait_out

    // While chk_line is set, every new line bit must be the next framer bit, in order
    always @(posedge mclk) begin
        if (strobe === 1'b1) begin
            if (chk_line) begin
                chk({30'h0, line_pos, line_neg}, {30'h0, tja_pat(out_cnt), ~tja_pat(out_cnt)});
            end
            out_cnt <= out_cnt + 16'h0001;
        end
    end

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, run, chk_line} = 5'b00000;
        paddr = 8'h00;
        pwdata = 32'h0;
        half = 8'h28;
        out_cnt = 16'h0000;
        mismatches = 0;
        total_checks = 0;
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        apb(1'b0, ADDR_CONFIG, 32'h0);
        chk(q, {24'h0, CONFIG_RST});
        apb(1'b0, ADDR_TXCFG0, 32'h0);
        chk(q, {24'h0, TXCFG0_RST});
        apb(1'b0, ADDR_IRQ_EN, 32'h0);
        chk(q, {24'h0, IRQ_EN_RST});
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk(q, {24'h0, STAT_RST});
        apb(1'b0, 8'h00, 32'h0);
        chk({q[30:0], err}, 32'h1);
        apb(1'b1, ADDR_CONFIG, 32'hFE);
        apb(1'b0, ADDR_CONFIG, 32'h0);
        chk(q, 32'h3E);
        apb(1'b1, ADDR_CONFIG, 32'h0);
        apb(1'b1, ADDR_TXCFG0, 32'h1);
        repeat (3) @(posedge mclk);
        chk({30'h0, pos_oe, neg_oe}, 32'h0);
        apb(1'b1, ADDR_TXCFG0, 32'h0);
        repeat (3) @(posedge mclk);
        chk({30'h0, pos_oe, neg_oe}, 32'h3);
        // Bypass: each framer bit appears once on the line
        base = sent;
        out_cnt <= sent;
        chk_line <= 1'b1;
        run <= 1'b1;
        wait_bits(base + 16'd20);
        run <= 1'b0;
        repeat (20) @(posedge mclk);
        chk(32'(out_cnt - base), 32'd20);
        for (int d = 0; d < 3; d++) begin
            hd = 16 << d;
            // E1 rates on the longest depth; framer a little faster than the read clock
            if (d == 2) begin
                half <= 8'h1E;
                apb(1'b1, ADDR_TXCFG0, 32'h2);
            end
            base = sent;
            out_cnt <= sent;
            chk_line <= 1'b1;
            // Peak mode on the two short depths, live mode on the longest; low corner at 64
            apb(1'b1, ADDR_CONFIG, (d < 2 ? 32'h20 : 32'h0) | (d == 1 ? 32'h8 : 32'h0) | 32'(d << 1) | 32'h1);
            run <= 1'b1;
            wait_out();
            k = sent - base;
            chk({31'h0, k >= hd && k <= hd + 2}, 32'h1);
            apb(1'b0, ADDR_MEASURE, 32'h0);
            if (d < 2) begin
                chk({31'h0, q[6:0] >= hd}, 32'h1);
            end else begin
                chk({31'h0, q[6:0] >= hd - 8 && q[6:0] <= hd + 8}, 32'h1);
            end
            wait_bits(sent + 16'd16);
            chk_line <= 1'b0;
            apb(1'b1, ADDR_CONFIG, 32'h0);
            run <= 1'b0;
            repeat (100) @(posedge mclk);
            apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        end
        // Underflow with the interrupt masked, then unmasked
        base = sent;
        out_cnt <= sent;
        apb(1'b1, ADDR_IRQ_EN, 32'h0);
        apb(1'b1, ADDR_CONFIG, 32'h1);
        run <= 1'b1;
        wait_out();
        run <= 1'b0;
        repeat (3000) @(posedge mclk);
        chk({31'h0, int_n}, 32'h1);
        apb(1'b1, ADDR_IRQ_EN, 32'h1);
        repeat (3) @(posedge mclk);
        chk({31'h0, int_n}, 32'h0);
        repeat (200) @(posedge mclk);
        chk({31'h0, int_n}, 32'h0);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk(q, 32'h1);
        repeat (3) @(posedge mclk);
        chk({31'h0, int_n}, 32'h1);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk(q, 32'h0);
        // Writes far faster than reads must overflow, even with limit mode on
        apb(1'b1, ADDR_CONFIG, 32'h11);
        half <= 8'h04;
        run <= 1'b1;
        for (n = 0; n < 4000 && int_n !== 1'b0; n++) @(posedge mclk);
        tmo(n, 4000);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk(q, 32'h1);
        run <= 1'b0;
        apb(1'b1, ADDR_CONFIG, 32'h0);
        apb(1'b1, ADDR_IRQ_EN, 32'h0);
        close_out();
    end
endmodule : tb_top
`default_nettype wire

/* verif/tja_framer.sv */
// Behavioural framer driving the transmit clock and data pins.
// Assumes the bench holds run and half steady while a frame is sent.
`timescale 1ns/1ps
`default_nettype none
module tja_framer (
    input  wire logic       mclk,
    input  wire logic       run,
    input  wire logic [7:0] half,
    output logic            tx_clk,
    output logic            tx_data,
    output logic [15:0]     sent
);
    logic [7:0] cnt;

    function automatic logic tja_pat(input logic [15:0] n);
        return n[0] ^ n[2] ^ (n[1] & n[3]);
    endfunction : tja_pat

    initial begin
        tx_clk = 1'b0;
        tx_data = 1'b0;
        sent = 16'h0000;
        cnt = 8'h00;
    end

    always @(posedge mclk) begin
        if (!run) begin
            // Clock stands still; data wanders so a stale bit never looks valid
            tx_clk <= 1'b0;
            tx_data <= ~tx_data;
            cnt <= 8'h00;
        end else begin
            if (!tx_clk) begin
                tx_data <= tja_pat(sent);
            end
            if (cnt + 8'h01 >= half) begin
                cnt <= 8'h00;
                tx_clk <= ~tx_clk;
                if (!tx_clk) begin
                    sent <= sent + 16'h0001;
                end
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule : tja_framer
`default_nettype wire
